// ==== src/dsp_pwm.v ====
// Dual-slope symmetric PWM timer: 16-bit up/down counter, two compare
// channels with buffered compare values, flags and pin drivers.
// Assumes an Avalon-MM master on the register port and an external load
// on the channel pins; everything runs on the single I/O clock.
//
// How it works
// - Modes 8 and 9 of the waveform mode field enable dual-slope counting.
// - Counter runs 0x0000 up to top, then back down to 0x0000, repeatedly.
// - Non-inverting clears on up-count match, sets on down-count match.
// - Top is capture value in mode 8, channel A active compare in mode 9.
// - Counter holds top for exactly one timer clock enable before descending.
// - A channel match sets that channel's compare match flag.
// - Overflow flag sets in the tick where buffers load, at the floor.
// - Reaching top sets channel A flag (mode 9) or capture flag (mode 8).
// - Compare writes go to buffers; in modes 8 and 9 active values change only at the floor.
// - Output mode 2 gives non-inverted PWM, mode 3 inverted PWM.
// - Waveform reaches the pin only when its direction bit selects output.
// - Compare at floor gives constant low, at top constant high (non-inverted).
// - Mode 9 with channel A output mode 1 toggles A on each match.
// - Timer clock enable comes from a prescaler dividing by 1,8,64,256,1024.
// - Period is twice top times the divider in I/O clock cycles.
// - Counter is synchronous to clk; the timer clock is only an enable.
// - Output mode 1 toggles only channel A in mode 9; else disconnected.
//
// The address map and the Avalon-MM slave port were decided locally.

`timescale 1ns/10ps
`include "dsp_consts.vh"

module dsp_pwm (
    // Clock and reset
    input wire clk,
    input wire arst_n,
    // Avalon-MM slave
    input wire [`DSP_ADDR_W-1:0] avs_address,
    input wire avs_read,
    input wire avs_write,
    input wire [3:0] avs_byteenable,
    input wire [31:0] avs_writedata,
    output reg [31:0] avs_readdata,
    output wire avs_waitrequest,
    // Channel pins, output only
    output wire channel_a_output_pin,
    output wire channel_a_output_pin_oe,
    output wire channel_b_output_pin,
    output wire channel_b_output_pin_oe
);

    // Bus handshake: every access waits exactly one cycle
    reg bus_ack;
    wire bus_req;
    wire wr_go;
    wire rd_go;

    assign bus_req = avs_read | avs_write;
    assign avs_waitrequest = bus_req & ~bus_ack;
    assign wr_go = avs_write & bus_ack;
    // Read data load in the wait cycle, so they stand when waitrequest drops
    assign rd_go = avs_read & ~bus_ack;

    // Software-visible state
    reg [`DSP_CTRL_W-1:0] ctrl;
    reg [15:0] counter_value;
    reg [15:0] capture_value;
    reg count_up;
    reg overflow_flag;
    reg capture_flag;
    reg [1:0] compare_match_flag;

    // Per-channel buffered and active compare values, flat for readback
    wire [31:0] cmp_buf_flat;
    wire [31:0] cmp_act_flat;
    wire [3:0] channel_output_mode;
    wire [1:0] channel_wave;
    wire [1:0] channel_match;
    wire [1:0] pin_direction_bit;

    // Control field decode
    wire [3:0] waveform_mode_field;
    wire [1:0] channel_a_output_mode;
    wire [1:0] channel_b_output_mode;
    wire [2:0] clock_select;

    assign waveform_mode_field = ctrl[`DSP_CTRL_MODE_MSB:`DSP_CTRL_MODE_LSB];
    assign channel_a_output_mode = ctrl[`DSP_CTRL_OMA_MSB:`DSP_CTRL_OMA_LSB];
    assign channel_b_output_mode = ctrl[`DSP_CTRL_OMB_MSB:`DSP_CTRL_OMB_LSB];
    assign clock_select = ctrl[`DSP_CTRL_CS_MSB:`DSP_CTRL_CS_LSB];
    assign channel_output_mode = {channel_b_output_mode, channel_a_output_mode};
    assign pin_direction_bit = {ctrl[`DSP_CTRL_DIR_B], ctrl[`DSP_CTRL_DIR_A]};

    // Timer clock enable
    wire timer_clock_enable;

    dsp_prescaler u_prescaler (
        .clk(clk),
        .arst_n(arst_n),
        .clock_select(clock_select),
        .timer_clock_enable(timer_clock_enable)
    );

    // Mode and top selection
    wire dual_mode;
    wire mode_top_capt;
    wire mode_top_cmpa;
    wire [15:0] top_value;
    wire at_top;
    wire at_floor;
    wire next_is_top;
    wire load_compares;
    wire slope_up;

    assign mode_top_capt = waveform_mode_field == `DSP_MODE_TOP_CAPT;
    assign mode_top_cmpa = waveform_mode_field == `DSP_MODE_TOP_CMPA;
    // Modes other than 8 and 9 leave the counter holding its value
    assign dual_mode = mode_top_capt | mode_top_cmpa;
    assign top_value = mode_top_capt ? capture_value : cmp_act_flat[15:0];
    // At or past top turns round, so a top lowered under the count recovers
    assign at_top = counter_value >= top_value;
    assign at_floor = counter_value == `DSP_FLOOR;
    assign next_is_top = count_up && (counter_value + 16'h0001 == top_value);
    // The buffers load in the tick where the counter steps onto the floor
    assign load_compares = timer_clock_enable && dual_mode && !count_up &&
        (counter_value == `DSP_FLOOR + 16'h0001);
    // A match at top counts as down-slope and at the floor as up-slope,
    // which is what pins the output steady at the two extreme compares
    assign slope_up = (count_up && !at_top) || at_floor;

    // Counter sequencer: next count and direction, taken only on ticks
    reg [15:0] next_counter_value;
    reg next_count_up;

    always @* begin
        next_counter_value = counter_value;
        next_count_up = count_up;
        if (count_up) begin
            if (at_top) begin
                // Top was held for one tick; turn round now
                next_count_up = 1'b0;
                next_counter_value = counter_value - 16'h0001;
            end else begin
                next_counter_value = counter_value + 16'h0001;
            end
        end else begin
            if (at_floor) begin
                next_count_up = 1'b1;
                next_counter_value = counter_value + 16'h0001;
            end else begin
                next_counter_value = counter_value - 16'h0001;
            end
        end
    end

    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            counter_value <= `DSP_FLOOR;
            count_up <= 1'b1;
        end else if (wr_go && avs_address == `DSP_OFS_COUNT) begin
            if (avs_byteenable[0])
                counter_value[7:0] <= avs_writedata[7:0];
            if (avs_byteenable[1])
                counter_value[15:8] <= avs_writedata[15:8];
        end else if (timer_clock_enable && dual_mode) begin
            counter_value <= next_counter_value;
            count_up <= next_count_up;
        end
    end

    // Compare channels
    genvar ch;
    generate
        for (ch = 0; ch < 2; ch = ch + 1) begin : g_chan
            reg [15:0] cmp_buf;
            reg [15:0] cmp_act;
            reg wave;
            wire [1:0] om;
            wire buf_wr;
            wire toggle_ok;

            assign om = channel_output_mode[2*ch+1:2*ch];
            assign buf_wr = wr_go &&
                (avs_address == (ch == 0 ? `DSP_OFS_CMP_A : `DSP_OFS_CMP_B));
            // Only channel A can toggle: it needs its own compare to be top
            assign toggle_ok = (ch == 0) && mode_top_cmpa;
            assign channel_match[ch] = timer_clock_enable && dual_mode &&
                (counter_value == cmp_act);

            // Lanes 0 and 1 write independently; the upper lanes are ignored
            always @(posedge clk or negedge arst_n) begin
                if (!arst_n) begin
                    cmp_buf <= `DSP_REG16_RESET;
                end else if (buf_wr) begin
                    if (avs_byteenable[0])
                        cmp_buf[7:0] <= avs_writedata[7:0];
                    if (avs_byteenable[1])
                        cmp_buf[15:8] <= avs_writedata[15:8];
                end
            end

            // Outside the dual-slope modes the active value follows the buffer
            always @(posedge clk or negedge arst_n) begin
                if (!arst_n)
                    cmp_act <= `DSP_REG16_RESET;
                else if (load_compares || !dual_mode)
                    cmp_act <= cmp_buf;
            end

            // A match sets the level; between matches the pin holds it
            always @(posedge clk or negedge arst_n) begin
                if (!arst_n) begin
                    wave <= 1'b0;
                end else if (channel_match[ch]) begin
                    case (om)
                        `DSP_OM_NONINV: wave <= ~slope_up;
                        `DSP_OM_INV: wave <= slope_up;
                        `DSP_OM_TOGGLE: wave <= toggle_ok ? ~wave : wave;
                        default: wave <= wave;
                    endcase
                end
            end

            assign channel_wave[ch] = wave;
            assign cmp_buf_flat[16*ch+15:16*ch] = cmp_buf;
            assign cmp_act_flat[16*ch+15:16*ch] = cmp_act;
        end
    endgenerate

    // Pin drive: disconnected modes leave the pin to the port logic
    wire [1:0] pin_connected;

    assign pin_connected[0] = channel_a_output_mode[1] ||
        (channel_a_output_mode == `DSP_OM_TOGGLE && mode_top_cmpa);
    assign pin_connected[1] = channel_b_output_mode[1];
    // Pin levels are flip-flops; only the enables are combinational
    assign channel_a_output_pin = channel_wave[0];
    assign channel_b_output_pin = channel_wave[1];
    assign channel_a_output_pin_oe = pin_connected[0] & pin_direction_bit[0];
    assign channel_b_output_pin_oe = pin_connected[1] & pin_direction_bit[1];

    // Flags: a hardware set in the clearing cycle wins
    wire flag_clr;
    wire [3:0] flag_clr_bits;
    wire top_event;

    assign flag_clr = wr_go && avs_address == `DSP_OFS_FLAGS && avs_byteenable[0];
    assign flag_clr_bits = flag_clr ? avs_writedata[3:0] : 4'h0;
    // Top is flagged as the counter arrives there, not as it leaves
    assign top_event = timer_clock_enable && dual_mode && next_is_top;

    // Overflow marks the floor, where the buffered compares take hold
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n)
            overflow_flag <= 1'b0;
        else if (load_compares)
            overflow_flag <= 1'b1;
        else if (flag_clr_bits[`DSP_FLAG_OVF])
            overflow_flag <= 1'b0;
    end

    // Mode 8 has no capture input here, so this flag only marks top
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n)
            capture_flag <= 1'b0;
        else if (top_event && mode_top_capt)
            capture_flag <= 1'b1;
        else if (flag_clr_bits[`DSP_FLAG_CAPT])
            capture_flag <= 1'b0;
    end

    // In mode 9 the channel A flag marks both its match and top
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            compare_match_flag <= 2'b00;
        end else begin
            if (channel_match[0] || (top_event && mode_top_cmpa))
                compare_match_flag[0] <= 1'b1;
            else if (flag_clr_bits[`DSP_FLAG_CMP_A])
                compare_match_flag[0] <= 1'b0;
            if (channel_match[1])
                compare_match_flag[1] <= 1'b1;
            else if (flag_clr_bits[`DSP_FLAG_CMP_B])
                compare_match_flag[1] <= 1'b0;
        end
    end

    // Control writes
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            ctrl <= `DSP_CTRL_RESET;
        end else if (wr_go && avs_address == `DSP_OFS_CTRL) begin
            if (avs_byteenable[0])
                ctrl[7:0] <= avs_writedata[7:0];
            if (avs_byteenable[1])
                ctrl[`DSP_CTRL_W-1:8] <= avs_writedata[`DSP_CTRL_W-1:8];
        end
    end

    // Capture value is top in mode 8 and not buffered, so a change acts at once
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            capture_value <= `DSP_REG16_RESET;
        end else if (wr_go && avs_address == `DSP_OFS_CAPTURE) begin
            if (avs_byteenable[0])
                capture_value[7:0] <= avs_writedata[7:0];
            if (avs_byteenable[1])
                capture_value[15:8] <= avs_writedata[15:8];
        end
    end

    // Read mux; unmapped addresses read zero
    // Compare offsets read the buffers; the values in use show at ACTIVE
    reg [31:0] next_readdata;

    always @* begin
        case (avs_address)
            `DSP_OFS_CTRL: next_readdata = {19'h00000, ctrl};
            `DSP_OFS_COUNT: next_readdata = {16'h0000, counter_value};
            `DSP_OFS_CMP_A: next_readdata = {16'h0000, cmp_buf_flat[15:0]};
            `DSP_OFS_CMP_B: next_readdata = {16'h0000, cmp_buf_flat[31:16]};
            `DSP_OFS_CAPTURE: next_readdata = {16'h0000, capture_value};
            `DSP_OFS_FLAGS: next_readdata = {28'h0000000, capture_flag,
                compare_match_flag, overflow_flag};
            `DSP_OFS_STATUS: next_readdata = {30'h00000000, dual_mode, count_up};
            `DSP_OFS_ACTIVE: next_readdata = cmp_act_flat;
            default: next_readdata = 32'h00000000;
        endcase
    end

    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            bus_ack <= 1'b0;
            avs_readdata <= 32'h00000000;
        end else begin
            // Ack flips each requested cycle: every access has one wait state
            bus_ack <= bus_req & ~bus_ack;
            if (rd_go)
                avs_readdata <= next_readdata;
        end
    end

endmodule

// ==== src/dsp_consts.vh ====
// Constants for the dual-slope symmetric PWM block: register map, field
// positions, reset values, mode codes and prescaler selections.
// Assumes a 32-bit Avalon-MM register bus with byte addresses.
`ifndef DSP_CONSTS_VH
`define DSP_CONSTS_VH

// Register byte offsets
`define DSP_ADDR_W 5
`define DSP_OFS_CTRL 5'h00
`define DSP_OFS_COUNT 5'h04
`define DSP_OFS_CMP_A 5'h08
`define DSP_OFS_CMP_B 5'h0C
`define DSP_OFS_CAPTURE 5'h10
`define DSP_OFS_FLAGS 5'h14
`define DSP_OFS_STATUS 5'h18
`define DSP_OFS_ACTIVE 5'h1C

// Control register fields
`define DSP_CTRL_MODE_LSB 0
`define DSP_CTRL_MODE_MSB 3
`define DSP_CTRL_OMA_LSB 4
`define DSP_CTRL_OMA_MSB 5
`define DSP_CTRL_OMB_LSB 6
`define DSP_CTRL_OMB_MSB 7
`define DSP_CTRL_CS_LSB 8
`define DSP_CTRL_CS_MSB 10
`define DSP_CTRL_DIR_A 11
`define DSP_CTRL_DIR_B 12
`define DSP_CTRL_W 13
`define DSP_CTRL_RESET 13'h0000

// Flag register bits
`define DSP_FLAG_OVF 0
`define DSP_FLAG_CMP_A 1
`define DSP_FLAG_CMP_B 2
`define DSP_FLAG_CAPT 3

// Waveform modes handled here
`define DSP_MODE_TOP_CAPT 4'h8
`define DSP_MODE_TOP_CMPA 4'h9

// Channel output modes
`define DSP_OM_OFF 2'h0
`define DSP_OM_TOGGLE 2'h1
`define DSP_OM_NONINV 2'h2
`define DSP_OM_INV 2'h3

// Counter values and reset values
`define DSP_FLOOR 16'h0000
`define DSP_REG16_RESET 16'h0000

// Prescaler selections and dividers
`define DSP_CS_STOP 3'h0
`define DSP_CS_DIV1 3'h1
`define DSP_CS_DIV8 3'h2
`define DSP_CS_DIV64 3'h3
`define DSP_CS_DIV256 3'h4
`define DSP_CS_DIV1024 3'h5
`define DSP_DIV8_LAST 10'h007
`define DSP_DIV64_LAST 10'h03F
`define DSP_DIV256_LAST 10'h0FF
`define DSP_DIV1024_LAST 10'h3FF

`endif

// ==== src/dsp_prescaler.v ====
// Prescaler: turns the I/O clock into a one-cycle timer clock enable.
// Assumes clk is the I/O clock; select changes restart the division.
`timescale 1ns/10ps
`include "dsp_consts.vh"

module dsp_prescaler (
    // Clock and reset
    input wire clk,
    input wire arst_n,
    // Divider selection
    input wire [2:0] clock_select,
    // Timer clock enable, one I/O clock wide
    output reg timer_clock_enable
);

    reg [9:0] div_count;
    reg [2:0] last_select;
    reg [9:0] div_last;
    reg next_tick;

    always @* begin
        case (clock_select)
            `DSP_CS_DIV8: div_last = `DSP_DIV8_LAST;
            `DSP_CS_DIV64: div_last = `DSP_DIV64_LAST;
            `DSP_CS_DIV256: div_last = `DSP_DIV256_LAST;
            `DSP_CS_DIV1024: div_last = `DSP_DIV1024_LAST;
            default: div_last = 10'h000;
        endcase
        next_tick = (clock_select != `DSP_CS_STOP) && (clock_select <= `DSP_CS_DIV1024) &&
            (div_count == div_last);
    end

    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            div_count <= 10'h000;
            last_select <= `DSP_CS_STOP;
            timer_clock_enable <= 1'b0;
        end else begin
            last_select <= clock_select;
            timer_clock_enable <= next_tick && (clock_select == last_select);
            if (clock_select != last_select || div_count == div_last)
                div_count <= 10'h000;
            else
                div_count <= div_count + 10'h001;
        end
    end

endmodule

// ==== verification/dsp_pwm_props.sv ====
// Checker for dsp_pwm: bus handshake, read-back values and pin enables.
// Assumes it is bound to dsp_pwm and sees only that module's ports.
`timescale 1ns/10ps
`include "dsp_consts.vh"

module dsp_pwm_props (
    // Clock and reset
    input wire clk,
    input wire arst_n,
    // Avalon-MM slave
    input wire [`DSP_ADDR_W-1:0] avs_address,
    input wire avs_read,
    input wire avs_write,
    input wire [3:0] avs_byteenable,
    input wire [31:0] avs_writedata,
    input wire [31:0] avs_readdata,
    input wire avs_waitrequest,
    // Channel pins
    input wire channel_a_output_pin,
    input wire channel_a_output_pin_oe,
    input wire channel_b_output_pin,
    input wire channel_b_output_pin_oe
);
    // Shadow of the control register, rebuilt from accepted writes only
    reg [12:0] ctrl;
    wire req = avs_read | avs_write;
    wire [3:0] mode = ctrl[3:0];
    wire [1:0] om_a = ctrl[5:4];
    wire [1:0] om_b = ctrl[7:6];
    wire dual = (mode == `DSP_MODE_TOP_CAPT) || (mode == `DSP_MODE_TOP_CMPA);
    wire rd_done = avs_read && !avs_waitrequest;

    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            ctrl <= 13'h0000;
        end else if (avs_write && !avs_waitrequest && avs_address == `DSP_OFS_CTRL) begin
            if (avs_byteenable[0]) begin
                ctrl[7:0] <= avs_writedata[7:0];
            end
            if (avs_byteenable[1]) begin
                ctrl[12:8] <= avs_writedata[12:8];
            end
        end
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!arst_n);

    sequence s_first;
        req && avs_waitrequest;
    endsequence
    sequence s_held_on;
        req && !avs_waitrequest ##1 req;
    endsequence

    AST_ONE_WAIT: assert property (s_first |=> !avs_waitrequest)
        else $error("request not answered after one wait cycle");
    AST_WAIT_AGAIN: assert property (s_held_on |-> avs_waitrequest)
        else $error("held request accepted twice without a wait cycle");
    AST_IDLE_NO_WAIT: assert property (!req |-> !avs_waitrequest)
        else $error("waitrequest high with no request");
    AST_UNMAPPED_ZERO: assert property (rd_done && avs_address[1:0] != 2'h0
        |-> avs_readdata == 32'h00000000)
        else $error("unmapped read returned nonzero data");
    AST_UPPER_ZERO: assert property (rd_done && avs_address != `DSP_OFS_ACTIVE
        |-> avs_readdata[31:16] == 16'h0000)
        else $error("upper half of a 16-bit register read nonzero");
    AST_CTRL_READBACK: assert property (rd_done && avs_address == `DSP_OFS_CTRL
        |-> avs_readdata[12:0] == ctrl)
        else $error("control read-back differs from last write");
    AST_STATUS_DUAL: assert property (
        rd_done && avs_address == `DSP_OFS_STATUS |-> avs_readdata[1] == dual)
        else $error("dual-slope status differs from waveform mode");
    AST_OE_A: assert property (
        channel_a_output_pin_oe == (ctrl[11] && (om_a[1] || (om_a == 2'h1 && mode == 4'h9))))
        else $error("channel A pin enable wrong for mode and direction");
    AST_OE_B: assert property (channel_b_output_pin_oe == (ctrl[12] && om_b[1]))
        else $error("channel B pin enable wrong for mode and direction");
endmodule

bind dsp_pwm dsp_pwm_props dsp_pwm_props_inst (
    .clk(clk), .arst_n(arst_n), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_byteenable(avs_byteenable),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .channel_a_output_pin(channel_a_output_pin),
    .channel_a_output_pin_oe(channel_a_output_pin_oe),
    .channel_b_output_pin(channel_b_output_pin),
    .channel_b_output_pin_oe(channel_b_output_pin_oe)
);

// ==== verification/dsp_load_model.sv ====
// External load on one channel pin: resolves the pin and measures it.
// Assumes the pin changes just after rising edges of clk.
`timescale 1ns/10ps

module dsp_load_model (
    // Clock and reset
    input wire clk,
    input wire arst_n,
    // Pin as driven by the block
    input wire pin,
    input wire pin_oe,
    // Measurements in I/O clock cycles
    output wire level,
    output reg [15:0] period,
    output reg [15:0] high_len,
    output reg [15:0] rises
);
    reg last;
    reg [15:0] since_rise;
    reg [15:0] run_high;

    // Pull-down on the pin: an undriven pin reads low, not its last value
    assign level = pin_oe ? pin : 1'b0;

    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            last <= 1'b0;
            since_rise <= 16'h0000;
            run_high <= 16'h0000;
            period <= 16'h0000;
            high_len <= 16'h0000;
            rises <= 16'h0000;
        end else begin
            last <= level;
            since_rise <= (level && !last) ? 16'h0001 : since_rise + 16'h0001;
            run_high <= (level && !last) ? 16'h0001 : run_high + 16'h0001;
            if (level && !last) begin
                period <= since_rise;
                rises <= rises + 16'h0001;
            end
            if (!level && last) begin
                high_len <= run_high;
            end
        end
    end
endmodule

// ==== verification/testbench.sv ====
// Self-checking bench for dsp_pwm with a measuring load on each pin.
// Assumes the design files and dsp_load_model are compiled first.
`timescale 1ns/10ps
`include "dsp_consts.vh"

module testbench;
    reg clk = 1'b0;
    reg arst_n = 1'b0;
    reg [`DSP_ADDR_W-1:0] adr = 5'h00;
    reg rd = 1'b0;
    reg wr = 1'b0;
    reg [31:0] wd = 32'h00000000;
    reg [31:0] d;
    wire [31:0] rdata;
    wire wt, pa, pa_oe, pb, pb_oe, la, lb;
    wire [15:0] per_a, hi_a, ris_a, per_b, hi_b, ris_b;
    integer n_fail = 0;
    integer compares = 0;
    integer cyc = 0;

    dsp_pwm dsp_pwm_inst (.clk(clk), .arst_n(arst_n), .avs_address(adr), .avs_read(rd),
        .avs_write(wr), .avs_byteenable(4'h3), .avs_writedata(wd), .avs_readdata(rdata),
        .avs_waitrequest(wt), .channel_a_output_pin(pa), .channel_a_output_pin_oe(pa_oe),
        .channel_b_output_pin(pb), .channel_b_output_pin_oe(pb_oe));
    dsp_load_model load_a_inst (.clk(clk), .arst_n(arst_n), .pin(pa), .pin_oe(pa_oe),
        .level(la), .period(per_a), .high_len(hi_a), .rises(ris_a));
    dsp_load_model load_b_inst (.clk(clk), .arst_n(arst_n), .pin(pb), .pin_oe(pb_oe),
        .level(lb), .period(per_b), .high_len(hi_b), .rises(ris_b));

    always #25 clk = ~clk;

    // Whole run needs about 40000 cycles
    always @(posedge clk) begin
        cyc = cyc + 1;
        if (cyc == 60000) begin
            n_fail = n_fail + 1;
            test_done;
        end
    end

    task check(input [31:0] seen, input [31:0] exp);
        begin
            compares = compares + 1;
            if (seen !== exp) begin
                n_fail = n_fail + 1;
                $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
            end
        end
    endtask

    // Waitrequest is sampled at rising edges; the request drops at the edge it is low
    task bus_wr(input [4:0] a, input [31:0] v);
        begin
            @(posedge clk);
            adr <= a;
            wd <= v;
            wr <= 1'b1;
            @(posedge clk);
            while (wt !== 1'b0) @(posedge clk);
            wr <= 1'b0;
        end
    endtask

    task bus_rd(input [4:0] a, output [31:0] v);
        begin
            @(posedge clk);
            adr <= a;
            rd <= 1'b1;
            @(posedge clk);
            while (wt !== 1'b0) @(posedge clk);
            v = rdata;
            rd <= 1'b0;
        end
    endtask

    task rdchk(input [4:0] a, input [31:0] exp);
        reg [31:0] v;
        begin
            bus_rd(a, v);
            check(v, exp);
        end
    endtask

    task wait_cyc(input integer n);
        begin
            repeat (n) @(posedge clk);
            @(negedge clk);
        end
    endtask

    task test_reset_idle;
        begin
            rdchk(`DSP_OFS_COUNT, 32'h0);
            rdchk(`DSP_OFS_STATUS, 32'h1);
            bus_wr(5'h02, 32'hFFFF);
            rdchk(5'h02, 32'h0);
            rdchk(`DSP_OFS_CTRL, 32'h0);
            bus_wr(`DSP_OFS_CTRL, 32'h010A);
            wait_cyc(20);
            rdchk(`DSP_OFS_COUNT, 32'h0);
            rdchk(`DSP_OFS_STATUS, 32'h1);
            $display("test_reset_idle done");
        end
    endtask

    // One read every 256 clocks at divide-by-256 sees the count of each tick once: two periods, top and floor twice each
    task test_count_seq;
        reg [15:0] s [0:15];
        integer i, tops, bots;
        begin
            tops = 0;
            bots = 0;
            bus_wr(`DSP_OFS_CMP_A, 32'h4);
            bus_wr(`DSP_OFS_CTRL, 32'h0409);
            for (i = 0; i < 16; i = i + 1) begin
                repeat (253) @(posedge clk);
                bus_rd(`DSP_OFS_COUNT, d);
                s[i] = d[15:0];
                tops = tops + ((s[i] == 16'h4) ? 1 : 0);
                bots = bots + ((s[i] == 16'h0) ? 1 : 0);
                if (i > 0) check({31'h0, (s[i] == s[i-1] + 16'h1) || (s[i] + 16'h1 == s[i-1])}, 1);
            end
            check(tops, 2);
            check(bots, 2);
            $display("test_count_seq done");
        end
    endtask

    task test_prescale;
        integer i, n;
        begin
            bus_wr(`DSP_OFS_CTRL, 32'h0);
            bus_wr(`DSP_OFS_CAPTURE, 32'h3);
            bus_wr(`DSP_OFS_CMP_A, 32'h1);
            bus_wr(`DSP_OFS_CMP_B, 32'h1);
            for (i = 1; i < 6; i = i + 1) begin
                n = (i == 1) ? 1 : (i == 2) ? 8 : (i == 3) ? 64 : (i == 4) ? 256 : 1024;
                bus_wr(`DSP_OFS_CTRL, (i << 8) | 32'h18B8);
                wait_cyc(26 * n + 20);
                check(per_a, 6 * n);
                check(hi_a, 4 * n);
                check(per_b, 6 * n);
                check(hi_b, 2 * n);
            end
            rdchk(`DSP_OFS_FLAGS, 32'hF);
            bus_wr(`DSP_OFS_CTRL, 32'h18B8);
            bus_wr(`DSP_OFS_FLAGS, 32'hF);
            rdchk(`DSP_OFS_FLAGS, 32'h0);
            $display("test_prescale done");
        end
    endtask

    task test_toggle_buffer;
        reg [15:0] r;
        begin
            bus_wr(`DSP_OFS_CTRL, 32'h0);
            bus_wr(`DSP_OFS_CMP_A, 32'h6);
            bus_wr(`DSP_OFS_CMP_B, 32'h0);
            bus_wr(`DSP_OFS_CTRL, 32'h1999);
            wait_cyc(120);
            check(per_a, 24);
            check(hi_a, 12);
            r = ris_b;
            wait_cyc(30);
            check(ris_b, r);
            check(lb, 0);
            rdchk(`DSP_OFS_FLAGS, 32'h7);
            bus_wr(`DSP_OFS_CTRL, 32'h1899);
            bus_wr(`DSP_OFS_CMP_B, 32'h6);
            rdchk(`DSP_OFS_ACTIVE, 32'h00000006);
            bus_wr(`DSP_OFS_CTRL, 32'h1999);
            wait_cyc(40);
            rdchk(`DSP_OFS_ACTIVE, 32'h00060006);
            r = ris_b;
            wait_cyc(30);
            check(ris_b, r);
            check(lb, 1);
            bus_wr(`DSP_OFS_CTRL, 32'h1959);
            @(negedge clk);
            check(pb_oe, 0);
            check(lb, 0);
            bus_wr(`DSP_OFS_CTRL, 32'h1199);
            @(negedge clk);
            check(pa_oe, 0);
            $display("test_toggle_buffer done");
        end
    endtask

    task test_done;
        begin
            $display("comparisons %0d, mismatches %0d", compares, n_fail);
            if (n_fail == 0 && compares > 0) begin
                $display("Simulation passed");
            end else begin
                $display("Simulation failed");
            end
            $finish;
        end
    endtask

    initial begin
        repeat (6) @(posedge clk);
        arst_n <= 1'b1;
        test_reset_idle;
        test_count_seq;
        test_prescale;
        test_toggle_buffer;
        test_done;
    end
endmodule
